//--- logic/gpb_pkg.sv
package gpb_pkg;
    // Pin counts and positions in the flat 26-pin vector
    localparam int NPIN = 26;
    localparam int P0_BASE = 0;
    localparam int P1_BASE = 8;
    localparam int P2_BASE = 10;
    localparam int P3_BASE = 18;
    localparam int P1_PINS = 2;
    localparam int BUZ_PIN = 0;

    // Register map, contiguous from the first control register
    localparam logic [7:0] REG_BASE = 8'he0;
    localparam int NREG = 18;
    localparam logic [7:0] A_P0_MODE_HI = 8'he0;
    localparam logic [7:0] A_P0_MODE_LO = 8'he1;
    localparam logic [7:0] A_P0_PULLUP = 8'he2;
    localparam logic [7:0] A_P1_MODE = 8'he3;
    localparam logic [7:0] A_P2_MODE_HI = 8'he4;
    localparam logic [7:0] A_P2_MODE_LO = 8'he5;
    localparam logic [7:0] A_P2_IRQ_CTRL = 8'he6;
    localparam logic [7:0] A_P2_PULLUP = 8'he7;
    localparam logic [7:0] A_P3_MODE_HI = 8'he8;
    localparam logic [7:0] A_P3_MODE_LO = 8'he9;
    localparam logic [7:0] A_P3_IRQ_EN = 8'hea;
    localparam logic [7:0] A_P3_PULLUP = 8'heb;
    localparam logic [7:0] A_P3_OD_SEL = 8'hec;
    localparam logic [7:0] A_P0_DATA = 8'hed;
    localparam logic [7:0] A_P1_DATA = 8'hee;
    localparam logic [7:0] A_P2_DATA = 8'hef;
    localparam logic [7:0] A_P3_DATA = 8'hf0;
    localparam logic [7:0] A_IRQ_PEND = 8'hf1;

    // Reset value and implemented-bit masks
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] MASK_FULL = 8'hff;
    localparam logic [7:0] MASK_P1_MODE = 8'h0f;
    localparam logic [7:0] MASK_P1_DATA = 8'h03;

    // Port 0 field codes
    localparam logic [1:0] P0M_IN = 2'h0;
    localparam logic [1:0] P0M_OUT = 2'h1;
    localparam logic [1:0] P0M_ALT = 2'h2;
    localparam logic [1:0] P0M_ANA = 2'h3;
    // Port 1 field codes
    localparam logic [1:0] P1M_IN = 2'h0;
    localparam logic [1:0] P1M_IN_PU = 2'h1;
    localparam logic [1:0] P1M_OUT = 2'h2;
    localparam logic [1:0] P1M_ANA = 2'h3;
    // Port 2 field codes
    localparam logic [1:0] P2M_IN = 2'h0;
    localparam logic [1:0] P2M_PP = 2'h1;
    localparam logic [1:0] P2M_OD = 2'h2;
    localparam logic [1:0] P2M_ALT = 2'h3;
    // Port 3 field codes
    localparam logic [1:0] P3M_IN_FALL = 2'h0;
    localparam logic [1:0] P3M_IN_RISE = 2'h1;
    localparam logic [1:0] P3M_IN_BOTH = 2'h2;
    localparam logic [1:0] P3M_OUT = 2'h3;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic we;
        logic re;
    } gpb_bus_t;

    typedef struct packed {
        logic [NPIN-1:0] out;
        logic [NPIN-1:0] oe_n;
        logic [NPIN-1:0] pu;
        logic [NPIN-1:0] ana;
    } gpb_pad_t;
endpackage

//--- logic/gpb_top.sv
`timescale 1ns/1ps
module gpb_top (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // Register port
    input wire gpb_pkg::gpb_bus_t bus_i,
    output logic [7:0] rdata_o,
    // Pads
    input wire logic [gpb_pkg::NPIN-1:0] pad_in_i,
    output gpb_pkg::gpb_pad_t pad_o,
    // Alternate functions from and to peripherals
    input wire logic [gpb_pkg::NPIN-1:0] alt_out_i,
    input wire logic [gpb_pkg::NPIN-1:0] alt_oe_i,
    output logic [gpb_pkg::NPIN-1:0] pin_level_o,
    // Interrupt request to the CPU
    output logic irq_n_o
);
    logic [7:0] regs_q [gpb_pkg::NREG];
    logic [7:0] regs_d [gpb_pkg::NREG];
    logic [gpb_pkg::NPIN-1:0] pad_q, pad_d;
    logic [7:0] p3_prev_q, p3_prev_d;
    logic [7:0] rdata_q, rdata_d;
    logic irq_n_q, irq_n_d;
    gpb_pkg::gpb_pad_t pads_q, pads_d;
    logic [gpb_pkg::NPIN-1:0] is_out;
    logic [7:0] pend_set;

    // Two-bit field of pin i out of a high/low control pair
    function automatic logic [1:0] field8(input logic [7:0] hi, input logic [7:0] lo,
                                          input int i);
        logic [1:0] f;
        if (i < 4) begin
            f = lo[2*i +: 2];
        end else begin
            f = hi[2*(i-4) +: 2];
        end
        return f;
    endfunction

    function automatic int ridx(input logic [7:0] a);
        return int'(a - gpb_pkg::REG_BASE);
    endfunction

    function automatic logic [7:0] wmask(input logic [7:0] a);
        logic [7:0] m;
        m = gpb_pkg::MASK_FULL;
        if (a == gpb_pkg::A_P1_MODE) begin
            m = gpb_pkg::MASK_P1_MODE;
        end else if (a == gpb_pkg::A_P1_DATA) begin
            m = gpb_pkg::MASK_P1_DATA;
        end
        return m;
    endfunction

    function automatic logic in_map(input logic [7:0] a);
        return (a >= gpb_pkg::A_P0_MODE_HI) && (a <= gpb_pkg::A_IRQ_PEND);
    endfunction

    // Pad steering per pin from its mode field
    always_comb begin
        logic [1:0] m;
        logic v;
        m = 2'h0;
        v = 1'b0;
        pads_d.out = '0;
        pads_d.oe_n = '1;
        pads_d.pu = '0;
        pads_d.ana = '0;
        is_out = '0;
        // Port 0
        for (int i = 0; i < 8; i++) begin
            m = field8(regs_q[ridx(gpb_pkg::A_P0_MODE_HI)],
                       regs_q[ridx(gpb_pkg::A_P0_MODE_LO)], i);
            unique case (m)
                gpb_pkg::P0M_IN: begin
                    pads_d.pu[gpb_pkg::P0_BASE+i] = regs_q[ridx(gpb_pkg::A_P0_PULLUP)][i];
                end
                gpb_pkg::P0M_OUT: begin
                    pads_d.out[gpb_pkg::P0_BASE+i] = regs_q[ridx(gpb_pkg::A_P0_DATA)][i];
                    pads_d.oe_n[gpb_pkg::P0_BASE+i] = 1'b0;
                    is_out[gpb_pkg::P0_BASE+i] = 1'b1;
                end
                gpb_pkg::P0M_ALT: begin
                    if (i == gpb_pkg::BUZ_PIN) begin
                        // Buzzer is a driven output, not an input alternate
                        pads_d.out[gpb_pkg::P0_BASE+i] = alt_out_i[gpb_pkg::P0_BASE+i];
                        pads_d.oe_n[gpb_pkg::P0_BASE+i] = 1'b0;
                    end else begin
                        pads_d.ana[gpb_pkg::P0_BASE+i] = 1'b1;
                    end
                end
                gpb_pkg::P0M_ANA: begin
                    pads_d.ana[gpb_pkg::P0_BASE+i] = 1'b1;
                end
            endcase
        end
        // Port 1
        for (int j = 0; j < gpb_pkg::P1_PINS; j++) begin
            m = regs_q[ridx(gpb_pkg::A_P1_MODE)][2*j +: 2];
            unique case (m)
                gpb_pkg::P1M_IN: begin
                end
                gpb_pkg::P1M_IN_PU: begin
                    pads_d.pu[gpb_pkg::P1_BASE+j] = 1'b1;
                end
                gpb_pkg::P1M_OUT: begin
                    pads_d.out[gpb_pkg::P1_BASE+j] = regs_q[ridx(gpb_pkg::A_P1_DATA)][j];
                    pads_d.oe_n[gpb_pkg::P1_BASE+j] = 1'b0;
                    is_out[gpb_pkg::P1_BASE+j] = 1'b1;
                end
                gpb_pkg::P1M_ANA: begin
                    pads_d.ana[gpb_pkg::P1_BASE+j] = 1'b1;
                end
            endcase
        end
        // Port 2
        for (int i = 0; i < 8; i++) begin
            m = field8(regs_q[ridx(gpb_pkg::A_P2_MODE_HI)],
                       regs_q[ridx(gpb_pkg::A_P2_MODE_LO)], i);
            v = regs_q[ridx(gpb_pkg::A_P2_DATA)][i];
            // Pull-up stays usable in every mode except push-pull output
            pads_d.pu[gpb_pkg::P2_BASE+i] = regs_q[ridx(gpb_pkg::A_P2_PULLUP)][i] &&
                                            (m != gpb_pkg::P2M_PP);
            unique case (m)
                gpb_pkg::P2M_IN: begin
                end
                gpb_pkg::P2M_PP: begin
                    pads_d.out[gpb_pkg::P2_BASE+i] = v;
                    pads_d.oe_n[gpb_pkg::P2_BASE+i] = 1'b0;
                    is_out[gpb_pkg::P2_BASE+i] = 1'b1;
                end
                gpb_pkg::P2M_OD: begin
                    pads_d.oe_n[gpb_pkg::P2_BASE+i] = v;
                    is_out[gpb_pkg::P2_BASE+i] = 1'b1;
                end
                gpb_pkg::P2M_ALT: begin
                    // Timer, capture, interrupt and serial lines
                    pads_d.out[gpb_pkg::P2_BASE+i] = alt_out_i[gpb_pkg::P2_BASE+i];
                    pads_d.oe_n[gpb_pkg::P2_BASE+i] = ~alt_oe_i[gpb_pkg::P2_BASE+i];
                end
            endcase
        end
        // Port 3
        for (int i = 0; i < 8; i++) begin
            m = field8(regs_q[ridx(gpb_pkg::A_P3_MODE_HI)],
                       regs_q[ridx(gpb_pkg::A_P3_MODE_LO)], i);
            if (m == gpb_pkg::P3M_OUT) begin
                // An enabled peripheral takes the pin over the data latch
                v = alt_oe_i[gpb_pkg::P3_BASE+i] ? alt_out_i[gpb_pkg::P3_BASE+i] :
                    regs_q[ridx(gpb_pkg::A_P3_DATA)][i];
                is_out[gpb_pkg::P3_BASE+i] = 1'b1;
                if (regs_q[ridx(gpb_pkg::A_P3_OD_SEL)][i]) begin
                    pads_d.oe_n[gpb_pkg::P3_BASE+i] = v;
                    pads_d.pu[gpb_pkg::P3_BASE+i] = regs_q[ridx(gpb_pkg::A_P3_PULLUP)][i];
                end else begin
                    pads_d.out[gpb_pkg::P3_BASE+i] = v;
                    pads_d.oe_n[gpb_pkg::P3_BASE+i] = 1'b0;
                end
            end else begin
                pads_d.pu[gpb_pkg::P3_BASE+i] = regs_q[ridx(gpb_pkg::A_P3_PULLUP)][i];
            end
        end
    end

    // Edge detection on port 3 inputs
    always_comb begin
        logic [1:0] m;
        logic rise;
        logic fall;
        m = 2'h0;
        rise = 1'b0;
        fall = 1'b0;
        pend_set = '0;
        p3_prev_d = pad_q[gpb_pkg::P3_BASE +: 8];
        for (int i = 0; i < 8; i++) begin
            m = field8(regs_q[ridx(gpb_pkg::A_P3_MODE_HI)],
                       regs_q[ridx(gpb_pkg::A_P3_MODE_LO)], i);
            rise = pad_q[gpb_pkg::P3_BASE+i] && !p3_prev_q[i];
            fall = !pad_q[gpb_pkg::P3_BASE+i] && p3_prev_q[i];
            unique case (m)
                gpb_pkg::P3M_IN_FALL: pend_set[i] = fall;
                gpb_pkg::P3M_IN_RISE: pend_set[i] = rise;
                gpb_pkg::P3M_IN_BOTH: pend_set[i] = rise || fall;
                gpb_pkg::P3M_OUT: pend_set[i] = 1'b0;
            endcase
            pend_set[i] = pend_set[i] && regs_q[ridx(gpb_pkg::A_P3_IRQ_EN)][i];
        end
    end

    // Register file writes, pending handling, read path
    always_comb begin
        logic [7:0] pend;
        logic [7:0] dat;
        pend = regs_q[ridx(gpb_pkg::A_IRQ_PEND)];
        dat = 8'h00;
        pad_d = pad_in_i;
        for (int k = 0; k < gpb_pkg::NREG; k++) begin
            regs_d[k] = regs_q[k];
        end
        if (bus_i.we && in_map(bus_i.addr)) begin
            if (bus_i.addr == gpb_pkg::A_IRQ_PEND) begin
                pend = pend & bus_i.wdata;
            end else begin
                regs_d[ridx(bus_i.addr)] = bus_i.wdata & wmask(bus_i.addr);
            end
        end
        // A new edge in the clearing cycle is kept
        regs_d[ridx(gpb_pkg::A_IRQ_PEND)] = pend | pend_set;
        irq_n_d = ~|(pend | pend_set);
        if (bus_i.re && in_map(bus_i.addr)) begin
            unique case (bus_i.addr)
                gpb_pkg::A_P0_DATA: begin
                    dat = (is_out[gpb_pkg::P0_BASE +: 8] & regs_q[ridx(bus_i.addr)]) |
                          (~is_out[gpb_pkg::P0_BASE +: 8] & pad_q[gpb_pkg::P0_BASE +: 8]);
                end
                gpb_pkg::A_P1_DATA: begin
                    dat = {6'h00, (is_out[gpb_pkg::P1_BASE +: 2] & regs_q[ridx(bus_i.addr)][1:0]) |
                          (~is_out[gpb_pkg::P1_BASE +: 2] & pad_q[gpb_pkg::P1_BASE +: 2])};
                end
                gpb_pkg::A_P2_DATA: begin
                    dat = (is_out[gpb_pkg::P2_BASE +: 8] & regs_q[ridx(bus_i.addr)]) |
                          (~is_out[gpb_pkg::P2_BASE +: 8] & pad_q[gpb_pkg::P2_BASE +: 8]);
                end
                gpb_pkg::A_P3_DATA: begin
                    dat = (is_out[gpb_pkg::P3_BASE +: 8] & regs_q[ridx(bus_i.addr)]) |
                          (~is_out[gpb_pkg::P3_BASE +: 8] & pad_q[gpb_pkg::P3_BASE +: 8]);
                end
                default: begin
                    dat = regs_q[ridx(bus_i.addr)];
                end
            endcase
        end
        rdata_d = dat;
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            for (int k = 0; k < gpb_pkg::NREG; k++) begin
                regs_q[k] <= gpb_pkg::REG_RESET;
            end
            pad_q <= '0;
            p3_prev_q <= 8'h00;
            rdata_q <= 8'h00;
            irq_n_q <= 1'b1;
            pads_q <= '{out: '0, oe_n: '1, pu: '0, ana: '0};
        end else begin
            for (int k = 0; k < gpb_pkg::NREG; k++) begin
                regs_q[k] <= regs_d[k];
            end
            pad_q <= pad_d;
            p3_prev_q <= p3_prev_d;
            rdata_q <= rdata_d;
            irq_n_q <= irq_n_d;
            pads_q <= pads_d;
        end
    end

    assign rdata_o = rdata_q;
    assign pad_o = pads_q;
    assign pin_level_o = pad_q;
    assign irq_n_o = irq_n_q;
endmodule // gpb_top

//--- bench/gpb_monitor.sv
`timescale 1ns/1ps
module gpb_monitor (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // Watched ports
    input wire gpb_pkg::gpb_bus_t bus_i,
    input wire logic [7:0] rdata_o,
    input wire gpb_pkg::gpb_pad_t pad_o,
    input wire logic [gpb_pkg::NPIN-1:0] pin_level_o,
    input wire logic irq_n_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    property p_reset;
        disable iff (1'b0)
        !rst_n_i |=> pad_o.oe_n == '1 && pad_o.ana == '0 && irq_n_o && rdata_o == 8'h00;
    endproperty
    a_reset: assert property (p_reset) else $error("pads not quiet after reset");

    property p_rd_idle;
        !$past(bus_i.re) |-> rdata_o == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");

    property p_unmapped;
        bus_i.re && (bus_i.addr < 8'he0 || bus_i.addr > 8'hf1) |=> rdata_o == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

    property p_p1_data;
        bus_i.re && bus_i.addr == gpb_pkg::A_P1_DATA |=> rdata_o[7:2] == 6'h00;
    endproperty
    a_p1_data: assert property (p_p1_data) else $error("port1 data spare bits set");

    property p_p1_mode;
        bus_i.re && bus_i.addr == gpb_pkg::A_P1_MODE |=> rdata_o[7:4] == 4'h0;
    endproperty
    a_p1_mode: assert property (p_p1_mode) else $error("port1 mode spare bits set");

    property p_p0_out;
        bus_i.we && bus_i.addr == gpb_pkg::A_P0_MODE_LO && bus_i.wdata[1:0] == gpb_pkg::P0M_OUT
            |=> ##1 !pad_o.oe_n[0];
    endproperty
    a_p0_out: assert property (p_p0_out) else $error("port0 pin0 not driven");

    property p_ana_drive;
        (pad_o.ana & ~pad_o.oe_n) == '0;
    endproperty
    a_ana_drive: assert property (p_ana_drive) else $error("analog pin driven");

    property p_irq_cause;
        $fell(irq_n_o) |-> pin_level_o[25:18] != $past(pin_level_o[25:18])
            || $past(pin_level_o[25:18]) != $past(pin_level_o[25:18], 2)
            || $past(pin_level_o[25:18], 2) != $past(pin_level_o[25:18], 3);
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("request without pin edge");

    property p_irq_clear;
        ($stable(pin_level_o)[*3] ##0 bus_i.we && bus_i.addr == gpb_pkg::A_IRQ_PEND
            && bus_i.wdata == 8'h00) ##1 $stable(pin_level_o)[*3] |-> irq_n_o;
    endproperty
    a_irq_clear: assert property (p_irq_clear) else $error("request stays after clear");
endmodule // gpb_monitor

bind gpb_top gpb_monitor mon_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .bus_i(bus_i),
    .rdata_o(rdata_o), .pad_o(pad_o), .pin_level_o(pin_level_o), .irq_n_o(irq_n_o));

//--- bench/gpb_pin_model.sv
`timescale 1ns/1ps
module gpb_pin_model (
    // Clock
    input wire logic mclk_i,
    // Pad drive from the block and from the outside world
    input wire gpb_pkg::gpb_pad_t pad_i,
    input wire logic [gpb_pkg::NPIN-1:0] ext_val_i,
    input wire logic [gpb_pkg::NPIN-1:0] ext_en_i,
    // Resolved pin levels
    output logic [gpb_pkg::NPIN-1:0] pad_in_o
);
    logic [gpb_pkg::NPIN-1:0] last_q;

    always_comb begin
        for (int i = 0; i < gpb_pkg::NPIN; i++) begin
            if (!pad_i.oe_n[i]) begin
                pad_in_o[i] = pad_i.out[i];
            end else if (ext_en_i[i]) begin
                pad_in_o[i] = ext_val_i[i];
            end else if (pad_i.pu[i]) begin
                pad_in_o[i] = 1'b1;
            end else begin
                // Floating pin: never show the stale level
                pad_in_o[i] = ~last_q[i];
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        last_q <= pad_in_o;
    end
endmodule // gpb_pin_model

//--- bench/tb.sv
`timescale 1ns/1ps
module tb;
    logic mclk_i, rst_n_i, irq_n;
    gpb_pkg::gpb_bus_t bus;
    gpb_pkg::gpb_pad_t pad;
    logic [7:0] rdata, got;
    logic [25:0] ext_val, ext_en, pad_in, alt_out, alt_oe, lvl;
    int failures, samples_checked;

    gpb_top dut_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .bus_i(bus), .rdata_o(rdata),
        .pad_in_i(pad_in), .pad_o(pad), .alt_out_i(alt_out), .alt_oe_i(alt_oe),
        .pin_level_o(lvl), .irq_n_o(irq_n));
    gpb_pin_model pin_u (.mclk_i(mclk_i), .pad_i(pad), .ext_val_i(ext_val),
        .ext_en_i(ext_en), .pad_in_o(pad_in));

    initial begin
        mclk_i = 1'b0;
        forever #20 mclk_i = ~mclk_i;
    end

    task stop_test;
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        bus <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
        @(posedge mclk_i);
        bus <= '0;
    endtask

    // Read data stand only in the cycle after the strobe
    task rdchk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk_i);
        bus <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
        @(posedge mclk_i);
        bus <= '0;
        #1 got = rdata;
        chk(got, exp);
    endtask

    task settle;
        repeat (3) @(posedge mclk_i);
        #1;
    endtask

    task do_reset;
        @(posedge mclk_i);
        rst_n_i <= 1'b0;
        repeat (4) @(posedge mclk_i);
        rst_n_i <= 1'b1;
    endtask

    // Drive one port 3 pin and see whether a request comes up
    task pin_edge(input int p, input logic v, input logic hit);
        @(posedge mclk_i);
        ext_val[18+p] <= v;
        repeat (5) @(posedge mclk_i);
        wr(gpb_pkg::A_IRQ_PEND, 8'hff);
        rdchk(gpb_pkg::A_IRQ_PEND, hit ? 8'(1 << p) : 8'h00);
        chk(irq_n, !hit);
        wr(gpb_pkg::A_IRQ_PEND, 8'h00);
        settle;
        chk(irq_n, 1'b1);
        rdchk(gpb_pkg::A_IRQ_PEND, 8'h00);
    endtask

    function automatic logic [7:0] rst_val(input logic [7:0] a);
        case (a)
            gpb_pkg::A_P0_DATA: return ext_val[7:0];
            gpb_pkg::A_P1_DATA: return {6'h00, ext_val[9:8]};
            gpb_pkg::A_P2_DATA: return ext_val[17:10];
            gpb_pkg::A_P3_DATA: return ext_val[25:18];
            default: return 8'h00;
        endcase
    endfunction

    initial begin
        #200000;
        failures++;
        stop_test;
    end

    initial begin
        rst_n_i = 1'b0;
        bus = '0;
        alt_out = '0;
        alt_oe = '0;
        ext_en = '1;
        ext_val = 26'h003c35a;
        failures = 0;
        samples_checked = 0;
        do_reset;
        for (int a = 'he0; a <= 'hf1; a++) rdchk(8'(a), rst_val(8'(a)));
        chk(pad.oe_n, 26'h3ffffff);
        for (int a = 'he0; a <= 'hec; a++) begin
            wr(8'(a), 8'ha5);
            rdchk(8'(a), (a == 'he3) ? 8'h05 : 8'ha5);
        end
        wr(8'hf2, 8'hff);
        rdchk(8'hf2, 8'h00);
        do_reset;
        wr(gpb_pkg::A_P0_MODE_LO, 8'h0d);
        wr(gpb_pkg::A_P0_DATA, 8'h01);
        wr(gpb_pkg::A_P1_MODE, 8'h0b);
        wr(gpb_pkg::A_P1_DATA, 8'h02);
        settle;
        chk({pad.oe_n[0], pad.out[0], pad.ana[1]}, 3'b011);
        chk(lvl[0], 1'b1);
        rdchk(gpb_pkg::A_P0_DATA, {ext_val[7:1], 1'b1});
        chk({pad.ana[9:8], pad.oe_n[9:8], pad.out[9]}, 5'b01011);
        wr(gpb_pkg::A_P2_MODE_LO, 8'hc2);
        wr(gpb_pkg::A_P2_PULLUP, 8'h01);
        wr(gpb_pkg::A_P2_DATA, 8'h00);
        alt_oe[13] <= 1'b1;
        alt_out[13] <= 1'b1;
        wr(gpb_pkg::A_P3_MODE_HI, 8'h03);
        wr(gpb_pkg::A_P3_OD_SEL, 8'h10);
        wr(gpb_pkg::A_P3_PULLUP, 8'h10);
        wr(gpb_pkg::A_P3_DATA, 8'h00);
        settle;
        chk({pad.oe_n[10], pad.pu[10]}, 2'b01);
        chk({pad.oe_n[13], pad.out[13]}, 2'b01);
        chk({pad.oe_n[22], pad.pu[22]}, 2'b01);
        wr(gpb_pkg::A_P2_DATA, 8'h01);
        wr(gpb_pkg::A_P3_DATA, 8'h10);
        settle;
        chk({pad.oe_n[10], pad.oe_n[22]}, 2'b11);
        @(posedge mclk_i);
        alt_oe[22] <= 1'b1;
        alt_out[22] <= 1'b0;
        settle;
        chk(pad.oe_n[22], 1'b0);
        wr(gpb_pkg::A_P3_MODE_LO, 8'ha4);
        wr(gpb_pkg::A_P3_IRQ_EN, 8'h07);
        settle;
        for (int p = 0; p < 4; p++) begin
            pin_edge(p, 1'b1, p == 1 || p == 2);
            pin_edge(p, 1'b0, p == 0 || p == 2);
        end
        stop_test;
    end
endmodule // tb
